// ===== hdl/sci_pkg.sv
// constants, field layouts and state types for the serial control and baud generator
package sci_pkg;

  // ----------------------------------------------------------------
  // register map (plain port address)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADR_STATUS = 3'h0;
  localparam logic [2:0] ADR_DATA = 3'h1;
  localparam logic [2:0] ADR_CTRL_ONE = 3'h2;
  localparam logic [2:0] ADR_CTRL_TWO = 3'h3;
  localparam logic [2:0] ADR_BAUD = 3'h4;
  localparam logic [2:0] ADR_EXT_RX = 3'h5;
  localparam logic [2:0] ADR_CTRL_THREE = 3'h6;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic txe_irq_en;
    logic txdone_irq_en;
    logic rx_irq_en;
    logic idle_irq_en;
    logic tx_on;
    logic rx_on;
    logic rx_mute;
    logic send_brk;
  } ctrl2_t;

  typedef struct packed {
    logic [1:0] first_prescale;
    logic [2:0] tx_div_sel;
    logic [2:0] rx_divider_sel;
  } baud_t;

  typedef struct packed {
    logic r8;
    logic t8;
    logic rsv5;
    logic word9;
    logic wake_addr;
    logic [2:0] rsv;
  } ctrl1_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic lin_slave;
    logic [4:0] rsv_lo;
  } ctrl3_t;

  typedef struct packed {
    logic tx_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic idle_flag;
    logic rx_overrun_flag;
    logic noise_flag;
    logic framing_flag;
    logic parity_flag;
  } status_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] EXT_RX_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hC0;

  // ----------------------------------------------------------------
  // timing: prescale terminal counts (factor minus one), oversampling
  // ----------------------------------------------------------------
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_3 = 4'h2;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_13 = 4'hC;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_S0 = 4'h7;
  localparam logic [3:0] OS_S1 = 4'h8;
  localparam logic [3:0] OS_S2 = 4'h9;
  localparam logic [3:0] TX_BITS8 = 4'h9;
  localparam logic [3:0] TX_BITS9 = 4'hA;
  localparam logic [3:0] RX_BITS8 = 4'h8;
  localparam logic [3:0] RX_BITS9 = 4'h9;
  localparam logic [7:0] IDLE_TICKS8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS9 = 8'hB0;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_OFF, TX_WAIT, TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_START, RX_DATA} rx_state_t;
  typedef enum logic [1:0] {TK_DATA, TK_PREAMBLE, TK_BREAK} tx_kind_t;

endpackage : sci_pkg

// ===== hdl/sci_uart.sv
// serial interface: control, data port, baud generators, transmitter and receiver
//
// How it works
// - tx empty flag raises irq when enabled
// - tx done flag raises irq when enabled
// - overrun or rx full raises irq when enabled
// - idle flag raises irq when enabled
// - tx_on enables or disables the transmitter
// - tx_on pulse mid-word queues one preamble
// - one bit time wait after tx_on set
// - rx_on enables receiver, hunting start bits
// - rx_mute mutes; wake-up clears it
// - address wake ignores mute writes while full
// - send_brk sends breaks while set, and one more after it is cleared
// - data writes tx_holding, reads rx_holding
// - first prescale divides by 1,3,4,13
// - tx divider divides by two to code
// - rx divider divides independently by two to code
// - conventional generator runs only outside lin slave
// - nonzero ext_rx_div further divides receive clock
// - ext_rx_div resets to zero, inactive
// - tx empty set on transfer, cleared by sequence
// - word9 selects nine data bits, else eight
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
module sci_uart (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic TXD_O,
  input wire logic RXD_I,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sci_pkg::ctrl2_t ctrl2_ff, nxt_ctrl2;
  sci_pkg::baud_t baud_ff, nxt_baud;
  sci_pkg::status_t stat_ff, nxt_stat;
  logic [7:0] ext_rx_ff, nxt_ext_rx;
  logic t8_ff, nxt_t8, word9_ff, nxt_word9, wake_addr_ff, nxt_wake_addr;
  logic lin_slave_ff, nxt_lin_slave, seq_armed_ff, nxt_seq_armed;
  logic [7:0] tx_hold_ff, nxt_tx_hold, rx_hold_ff, nxt_rx_hold, rdata_ff, nxt_rdata;
  logic hold_valid_ff, nxt_hold_valid, hold_t8_ff, nxt_hold_t8, r8_ff, nxt_r8;
  logic brk_pend_ff, nxt_brk_pend, pre_pend_ff, nxt_pre_pend;
  logic [3:0] pre_cnt_ff, nxt_pre_cnt;
  logic [6:0] div_cnt_ff, nxt_div_cnt;
  logic [7:0] ext_cnt_ff, nxt_ext_cnt;
  logic pre_tick, tx_tick, rx_conv_tick, rx_tick;
  logic [3:0] pre_last;
  sci_pkg::tx_state_t tx_st_ff, nxt_tx_st;
  sci_pkg::tx_kind_t tx_kind_ff, nxt_tx_kind;
  logic [3:0] tx_os_ff, nxt_tx_os, tx_bits_ff, nxt_tx_bits;
  logic [10:0] tx_sh_ff, nxt_tx_sh;
  logic txd_ff, nxt_txd, tx_take, tx_data_done, tx_bit_end;
  sci_pkg::rx_state_t rx_st_ff, nxt_rx_st;
  logic rx_s1_ff, rx_s2_ff, rx_prev_ff;
  logic [3:0] rx_os_ff, nxt_rx_os, rx_bits_ff, nxt_rx_bits;
  logic [9:0] rx_sh_ff, nxt_rx_sh;
  logic [1:0] vote_ff, nxt_vote;
  logic noise_ff, nxt_noise, idle_armed_ff, nxt_idle_armed;
  logic [7:0] idle_cnt_ff, nxt_idle_cnt, idle_target;
  logic rx_xfer, rx_done, idle_event, idle_det, wake_hit;
  logic wr_data, rd_data, rd_stat, wr_ctrl2, rx_bit;
  sci_pkg::ctrl1_t wd_ctrl1;
  sci_pkg::ctrl2_t wd_ctrl2;
  sci_pkg::ctrl3_t wd_ctrl3;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // low code bits set: the counter hits the mask once every 2**code steps
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = ~(7'h7F << code);
  endfunction : div_mask

  assign wr_data = WR_I && (ADDR_I == sci_pkg::ADR_DATA);
  assign rd_data = RD_I && (ADDR_I == sci_pkg::ADR_DATA);
  assign rd_stat = RD_I && (ADDR_I == sci_pkg::ADR_STATUS);
  assign wr_ctrl2 = WR_I && (ADDR_I == sci_pkg::ADR_CTRL_TWO);
  assign wd_ctrl1 = sci_pkg::ctrl1_t'(WDATA_I);
  assign wd_ctrl2 = sci_pkg::ctrl2_t'(WDATA_I);
  assign wd_ctrl3 = sci_pkg::ctrl3_t'(WDATA_I);

  // ----------------------------------------------------------------
  // baud generators
  // ----------------------------------------------------------------
  always_comb begin
    case (baud_ff.first_prescale)
      2'h0: pre_last = sci_pkg::PRE_LAST_1;
      2'h1: pre_last = sci_pkg::PRE_LAST_3;
      2'h2: pre_last = sci_pkg::PRE_LAST_4;
      default: pre_last = sci_pkg::PRE_LAST_13;
    endcase
    pre_tick = !lin_slave_ff && (pre_cnt_ff == pre_last);
    tx_tick = pre_tick && ((div_cnt_ff & div_mask(baud_ff.tx_div_sel))
      == div_mask(baud_ff.tx_div_sel));
    rx_conv_tick = pre_tick && ((div_cnt_ff & div_mask(baud_ff.rx_divider_sel))
      == div_mask(baud_ff.rx_divider_sel));
    if (ext_rx_ff == 8'h00) begin
      rx_tick = rx_conv_tick;
    end else begin
      rx_tick = rx_conv_tick && (ext_cnt_ff == 8'(ext_rx_ff - 8'h01));
    end
    nxt_pre_cnt = pre_cnt_ff;
    nxt_div_cnt = div_cnt_ff;
    nxt_ext_cnt = ext_cnt_ff;
    if (lin_slave_ff) begin
      nxt_pre_cnt = 4'h0;
    end else if (pre_tick) begin
      nxt_pre_cnt = 4'h0;
      nxt_div_cnt = 7'(div_cnt_ff + 7'h01);
    end else begin
      nxt_pre_cnt = 4'(pre_cnt_ff + 4'h1);
    end
    if (ext_rx_ff == 8'h00) begin
      nxt_ext_cnt = 8'h00;
    end else if (rx_tick) begin
      nxt_ext_cnt = 8'h00;
    end else if (rx_conv_tick) begin
      nxt_ext_cnt = 8'(ext_cnt_ff + 8'h01);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      pre_cnt_ff <= 4'h0;
      div_cnt_ff <= 7'h00;
      ext_cnt_ff <= 8'h00;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      div_cnt_ff <= nxt_div_cnt;
      ext_cnt_ff <= nxt_ext_cnt;
    end
  end

  // ----------------------------------------------------------------
  // registers, status flags and data port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl2 = ctrl2_ff;
    nxt_baud = baud_ff;
    nxt_ext_rx = ext_rx_ff;
    nxt_t8 = t8_ff;
    nxt_word9 = word9_ff;
    nxt_wake_addr = wake_addr_ff;
    nxt_lin_slave = lin_slave_ff;
    nxt_stat = stat_ff;
    nxt_seq_armed = seq_armed_ff;
    nxt_tx_hold = tx_hold_ff;
    nxt_hold_valid = hold_valid_ff;
    nxt_hold_t8 = hold_t8_ff;
    nxt_rx_hold = rx_hold_ff;
    nxt_r8 = r8_ff;
    nxt_brk_pend = brk_pend_ff;
    nxt_pre_pend = pre_pend_ff;
    nxt_rdata = 8'h00;
    if (WR_I) begin
      case (ADDR_I)
        sci_pkg::ADR_CTRL_TWO: begin
          nxt_ctrl2 = sci_pkg::ctrl2_t'(WDATA_I);
          if (wake_addr_ff && stat_ff.rx_full_flag) begin
            nxt_ctrl2.rx_mute = ctrl2_ff.rx_mute;
          end
        end
        sci_pkg::ADR_CTRL_ONE: begin
          nxt_t8 = wd_ctrl1.t8;
          nxt_word9 = wd_ctrl1.word9;
          nxt_wake_addr = wd_ctrl1.wake_addr;
        end
        sci_pkg::ADR_CTRL_THREE: nxt_lin_slave = wd_ctrl3.lin_slave;
        sci_pkg::ADR_BAUD: nxt_baud = sci_pkg::baud_t'(WDATA_I);
        sci_pkg::ADR_EXT_RX: nxt_ext_rx = WDATA_I;
        sci_pkg::ADR_DATA: begin
          nxt_tx_hold = WDATA_I;
          nxt_hold_t8 = t8_ff;
        end
        default: ;
      endcase
    end
    if (wake_hit) begin
      nxt_ctrl2.rx_mute = 1'b0;
    end
    // one break after send_brk falls, one preamble after tx_on pulses mid-word
    if (wr_ctrl2 && ctrl2_ff.send_brk && !wd_ctrl2.send_brk) begin
      nxt_brk_pend = 1'b1;
    end else if (tx_take && (nxt_tx_kind == sci_pkg::TK_BREAK)) begin
      nxt_brk_pend = 1'b0;
    end
    if (wr_ctrl2 && !ctrl2_ff.tx_on && wd_ctrl2.tx_on
        && (tx_st_ff == sci_pkg::TX_SHIFT)) begin
      nxt_pre_pend = 1'b1;
    end else if (tx_take && (nxt_tx_kind == sci_pkg::TK_PREAMBLE)) begin
      nxt_pre_pend = 1'b0;
    end
    // status read arms the clearing sequence; the data access completes it
    if (rd_stat) begin
      nxt_seq_armed = 1'b1;
    end else if (rd_data || wr_data) begin
      nxt_seq_armed = 1'b0;
    end
    if (rd_data && seq_armed_ff) begin
      nxt_stat.rx_full_flag = 1'b0;
      nxt_stat.idle_flag = 1'b0;
      nxt_stat.rx_overrun_flag = 1'b0;
      nxt_stat.noise_flag = 1'b0;
      nxt_stat.framing_flag = 1'b0;
    end
    if (wr_data && seq_armed_ff) begin
      nxt_stat.tx_empty_flag = 1'b0;
      nxt_stat.tx_done_flag = 1'b0;
    end
    // hardware sets win over the software clear
    if (tx_take && (nxt_tx_kind == sci_pkg::TK_DATA)) begin
      nxt_stat.tx_empty_flag = 1'b1;
      nxt_hold_valid = 1'b0;
    end
    if (wr_data) begin
      nxt_hold_valid = 1'b1;
    end
    if (tx_data_done) begin
      nxt_stat.tx_done_flag = 1'b1;
    end
    if (rx_xfer) begin
      if (nxt_stat.rx_full_flag) begin
        nxt_stat.rx_overrun_flag = 1'b1;
      end else begin
        nxt_stat.rx_full_flag = 1'b1;
        nxt_stat.noise_flag = noise_ff;
        nxt_stat.framing_flag = !rx_sh_ff[9];
        nxt_rx_hold = word9_ff ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
        nxt_r8 = rx_sh_ff[8];
      end
    end
    if (idle_det) begin
      nxt_stat.idle_flag = 1'b1;
    end
    if (RD_I) begin
      case (ADDR_I)
        sci_pkg::ADR_STATUS: nxt_rdata = stat_ff;
        sci_pkg::ADR_DATA: nxt_rdata = rx_hold_ff;
        sci_pkg::ADR_CTRL_ONE: nxt_rdata = {r8_ff, t8_ff, 1'b0, word9_ff, wake_addr_ff, 3'h0};
        sci_pkg::ADR_CTRL_TWO: nxt_rdata = ctrl2_ff;
        sci_pkg::ADR_BAUD: nxt_rdata = baud_ff;
        sci_pkg::ADR_EXT_RX: nxt_rdata = ext_rx_ff;
        sci_pkg::ADR_CTRL_THREE: nxt_rdata = {2'h0, lin_slave_ff, 5'h00};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      ctrl2_ff <= sci_pkg::ctrl2_t'(sci_pkg::CTRL_TWO_RST);
      baud_ff <= sci_pkg::baud_t'(sci_pkg::BAUD_RST);
      ext_rx_ff <= sci_pkg::EXT_RX_RST;
      stat_ff <= sci_pkg::status_t'(sci_pkg::STATUS_RST);
      t8_ff <= 1'b0;
      word9_ff <= 1'b0;
      wake_addr_ff <= 1'b0;
      lin_slave_ff <= 1'b0;
      seq_armed_ff <= 1'b0;
      tx_hold_ff <= 8'h00;
      hold_valid_ff <= 1'b0;
      hold_t8_ff <= 1'b0;
      rx_hold_ff <= 8'h00;
      r8_ff <= 1'b0;
      brk_pend_ff <= 1'b0;
      pre_pend_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ctrl2_ff <= nxt_ctrl2;
      baud_ff <= nxt_baud;
      ext_rx_ff <= nxt_ext_rx;
      stat_ff <= nxt_stat;
      t8_ff <= nxt_t8;
      word9_ff <= nxt_word9;
      wake_addr_ff <= nxt_wake_addr;
      lin_slave_ff <= nxt_lin_slave;
      seq_armed_ff <= nxt_seq_armed;
      tx_hold_ff <= nxt_tx_hold;
      hold_valid_ff <= nxt_hold_valid;
      hold_t8_ff <= nxt_hold_t8;
      rx_hold_ff <= nxt_rx_hold;
      r8_ff <= nxt_r8;
      brk_pend_ff <= nxt_brk_pend;
      pre_pend_ff <= nxt_pre_pend;
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA_O = rdata_ff;
  assign IRQ_O = (ctrl2_ff.txe_irq_en && stat_ff.tx_empty_flag)
    || (ctrl2_ff.txdone_irq_en && stat_ff.tx_done_flag)
    || (ctrl2_ff.rx_irq_en && (stat_ff.rx_overrun_flag || stat_ff.rx_full_flag))
    || (ctrl2_ff.idle_irq_en && stat_ff.idle_flag);

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  assign tx_bit_end = tx_tick && (tx_os_ff == sci_pkg::OS_LAST);

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_kind = tx_kind_ff;
    nxt_tx_os = tx_os_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_sh = tx_sh_ff;
    tx_take = 1'b0;
    tx_data_done = 1'b0;
    if (tx_tick) begin
      nxt_tx_os = 4'(tx_os_ff + 4'h1);
    end
    case (tx_st_ff)
      sci_pkg::TX_OFF: begin
        nxt_tx_os = 4'h0;
        if (ctrl2_ff.tx_on) begin
          nxt_tx_st = sci_pkg::TX_WAIT;
        end
      end
      sci_pkg::TX_WAIT: begin
        if (!ctrl2_ff.tx_on) begin
          nxt_tx_st = sci_pkg::TX_OFF;
        end else if (tx_bit_end) begin
          nxt_tx_st = sci_pkg::TX_IDLE;
        end
      end
      sci_pkg::TX_IDLE: begin
        nxt_tx_os = 4'h0;
        nxt_tx_bits = word9_ff ? sci_pkg::TX_BITS9 : sci_pkg::TX_BITS8;
        if (!ctrl2_ff.tx_on) begin
          nxt_tx_st = sci_pkg::TX_OFF;
        end else if (pre_pend_ff) begin
          tx_take = 1'b1;
          nxt_tx_kind = sci_pkg::TK_PREAMBLE;
          nxt_tx_sh = 11'h7FF;
          nxt_tx_st = sci_pkg::TX_SHIFT;
        end else if (ctrl2_ff.send_brk || brk_pend_ff) begin
          tx_take = 1'b1;
          nxt_tx_kind = sci_pkg::TK_BREAK;
          nxt_tx_sh = 11'h000;
          nxt_tx_st = sci_pkg::TX_SHIFT;
        end else if (hold_valid_ff) begin
          tx_take = 1'b1;
          nxt_tx_kind = sci_pkg::TK_DATA;
          nxt_tx_sh = word9_ff ? {1'b1, hold_t8_ff, tx_hold_ff, 1'b0}
            : {2'h3, tx_hold_ff, 1'b0};
          nxt_tx_st = sci_pkg::TX_SHIFT;
        end
      end
      sci_pkg::TX_SHIFT: begin
        if (tx_bit_end) begin
          nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
          if (tx_bits_ff == 4'h0) begin
            tx_data_done = (tx_kind_ff == sci_pkg::TK_DATA);
            nxt_tx_st = ctrl2_ff.tx_on ? sci_pkg::TX_IDLE : sci_pkg::TX_OFF;
          end else begin
            nxt_tx_bits = 4'(tx_bits_ff - 4'h1);
          end
        end
      end
      default: nxt_tx_st = sci_pkg::TX_OFF;
    endcase
    nxt_txd = (nxt_tx_st == sci_pkg::TX_SHIFT) ? nxt_tx_sh[0] : 1'b1;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      tx_st_ff <= sci_pkg::TX_OFF;
      tx_kind_ff <= sci_pkg::TK_DATA;
      tx_os_ff <= 4'h0;
      tx_bits_ff <= 4'h0;
      tx_sh_ff <= 11'h7FF;
      txd_ff <= 1'b1;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_kind_ff <= nxt_tx_kind;
      tx_os_ff <= nxt_tx_os;
      tx_bits_ff <= nxt_tx_bits;
      tx_sh_ff <= nxt_tx_sh;
      txd_ff <= nxt_txd;
    end
  end

  assign TXD_O = txd_ff;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign idle_target = word9_ff ? sci_pkg::IDLE_TICKS9 : sci_pkg::IDLE_TICKS8;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_os = rx_os_ff;
    nxt_rx_bits = rx_bits_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_vote = vote_ff;
    nxt_noise = noise_ff;
    nxt_idle_cnt = idle_cnt_ff;
    nxt_idle_armed = idle_armed_ff;
    rx_done = 1'b0;
    idle_event = 1'b0;
    rx_bit = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & rx_s2_ff) | (vote_ff[1] & rx_s2_ff);
    if (rx_tick) begin
      nxt_rx_os = 4'(rx_os_ff + 4'h1);
    end
    case (rx_st_ff)
      sci_pkg::RX_OFF: begin
        nxt_idle_cnt = 8'h00;
        if (ctrl2_ff.rx_on) begin
          nxt_rx_st = sci_pkg::RX_HUNT;
        end
      end
      sci_pkg::RX_HUNT: begin
        nxt_rx_os = 4'h0;
        nxt_noise = 1'b0;
        nxt_rx_bits = word9_ff ? sci_pkg::RX_BITS9 : sci_pkg::RX_BITS8;
        if (!rx_s2_ff) begin
          nxt_idle_cnt = 8'h00;
        end else if (rx_tick && (idle_cnt_ff != idle_target)) begin
          nxt_idle_cnt = 8'(idle_cnt_ff + 8'h01);
          idle_event = (8'(idle_cnt_ff + 8'h01) == idle_target);
        end
        if (!ctrl2_ff.rx_on) begin
          nxt_rx_st = sci_pkg::RX_OFF;
        end else if (rx_prev_ff && !rx_s2_ff) begin
          nxt_rx_st = sci_pkg::RX_START;
        end
      end
      sci_pkg::RX_START: begin
        nxt_idle_cnt = 8'h00;
        if (rx_tick && (rx_os_ff == sci_pkg::OS_S1) && rx_s2_ff) begin
          nxt_rx_st = sci_pkg::RX_HUNT;
        end else if (rx_tick && (rx_os_ff == sci_pkg::OS_LAST)) begin
          nxt_rx_st = sci_pkg::RX_DATA;
        end
      end
      sci_pkg::RX_DATA: begin
        if (rx_tick && (rx_os_ff == sci_pkg::OS_S0)) begin
          nxt_vote[0] = rx_s2_ff;
        end
        if (rx_tick && (rx_os_ff == sci_pkg::OS_S1)) begin
          nxt_vote[1] = rx_s2_ff;
        end
        if (rx_tick && (rx_os_ff == sci_pkg::OS_S2)) begin
          nxt_rx_sh = {rx_bit, rx_sh_ff[9:1]};
          nxt_noise = noise_ff || (vote_ff[0] != vote_ff[1]) || (vote_ff[1] != rx_s2_ff);
        end
        if (rx_tick && (rx_os_ff == sci_pkg::OS_LAST)) begin
          if (rx_bits_ff == 4'h0) begin
            rx_done = 1'b1;
            nxt_rx_st = ctrl2_ff.rx_on ? sci_pkg::RX_HUNT : sci_pkg::RX_OFF;
          end else begin
            nxt_rx_bits = 4'(rx_bits_ff - 4'h1);
          end
        end
      end
      default: nxt_rx_st = sci_pkg::RX_OFF;
    endcase
    // muted words are dropped unless an address mark wakes the receiver
    wake_hit = (ctrl2_ff.rx_mute && rx_done && wake_addr_ff && rx_sh_ff[8])
      || (ctrl2_ff.rx_mute && idle_event && !wake_addr_ff);
    rx_xfer = rx_done && (!ctrl2_ff.rx_mute || wake_hit);
    // idle detection needs a word seen first, so the flag fires once per gap
    idle_det = idle_event && !ctrl2_ff.rx_mute && idle_armed_ff;
    if (rx_xfer) begin
      nxt_idle_armed = 1'b1;
    end else if (idle_det) begin
      nxt_idle_armed = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
      rx_st_ff <= sci_pkg::RX_OFF;
      rx_os_ff <= 4'h0;
      rx_bits_ff <= 4'h0;
      rx_sh_ff <= 10'h000;
      vote_ff <= 2'h3;
      noise_ff <= 1'b0;
      idle_cnt_ff <= 8'h00;
      idle_armed_ff <= 1'b0;
    end else begin
      rx_s1_ff <= RXD_I;
      rx_s2_ff <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
      rx_st_ff <= nxt_rx_st;
      rx_os_ff <= nxt_rx_os;
      rx_bits_ff <= nxt_rx_bits;
      rx_sh_ff <= nxt_rx_sh;
      vote_ff <= nxt_vote;
      noise_ff <= nxt_noise;
      idle_cnt_ff <= nxt_idle_cnt;
      idle_armed_ff <= nxt_idle_armed;
    end
  end

endmodule : sci_uart

// ===== bench/sci_uart_assertions.sv
// port checker for the serial control block
`timescale 1ns/10ps
module sci_uart_assertions (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic TXD_O,
  input wire logic RXD_I,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence wr_rd_s(logic [2:0] a);
    WR_I && ADDR_I == a ##1 !WR_I ##1 RD_I && ADDR_I == a;
  endsequence
  irq_off_a: assert property (WR_I && ADDR_I == sci_pkg::ADR_CTRL_TWO && WDATA_I[7:4] == 4'h0 |=> !IRQ_O)
    else $error("irq raised with enables off");
  ctrl_rb_a: assert property (wr_rd_s(sci_pkg::ADR_CTRL_TWO) |=> (RDATA_O & 8'hFD) == ($past(WDATA_I, 3) & 8'hFD))
    else $error("control_two readback wrong");
  baud_rb_a: assert property (wr_rd_s(sci_pkg::ADR_BAUD) |=> RDATA_O == $past(WDATA_I, 3))
    else $error("baud_select readback wrong");
  ext_rb_a: assert property (wr_rd_s(sci_pkg::ADR_EXT_RX) |=> RDATA_O == $past(WDATA_I, 3))
    else $error("rx_ext_divider readback wrong");
  unmapped_rd_a: assert property (RD_I && ADDR_I == 3'h7 |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data outside read slot");
  low_hold_a: assert property ($fell(TXD_O) |=> !TXD_O [*8])
    else $error("serial low bit too short");
  high_hold_a: assert property ($rose(TXD_O) |=> TXD_O [*8])
    else $error("serial high bit too short");
  tx_start_c: cover property ($fell(TXD_O));
  irq_c: cover property ($rose(IRQ_O));
  data_rd_c: cover property (RD_I && ADDR_I == sci_pkg::ADR_DATA);
endmodule : sci_uart_assertions

// ===== bench/sci_node.sv
// remote serial node model: frame sender and frame catcher
`timescale 1ns/10ps
module sci_node (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  initial rxd_o = 1'b1;
  // start bit, data lsb first, stop bit leaves line idle high
  task automatic send_byte(input logic [7:0] d, input int bt);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= fr[i];
      repeat (bt) @(posedge clk_i);
    end
  endtask : send_byte
  // samples each data bit in its middle
  task automatic rx_byte(output logic [7:0] d, input int bt);
    @(negedge txd_i);
    repeat (bt / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk_i);
      d[i] = txd_i;
    end
  endtask : rx_byte
endmodule : sci_node

// ===== bench/sci_uart_tb_top.sv
// self-checking bench for the serial control block
`timescale 1ns/10ps
module sci_uart_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic txd;
  logic rxd;
  logic irq;
  logic [7:0] got;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  sci_uart sci_uart_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TXD_O(txd), .RXD_I(rxd), .IRQ_O(irq));
  sci_node sci_node_i (.clk_i(clk_sys), .txd_i(txd), .rxd_o(rxd));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask : rd_reg
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(sci_pkg::ADR_CTRL_TWO, 8'h00, "control_two");
    rd_reg(sci_pkg::ADR_BAUD, 8'h00, "baud_select");
    rd_reg(sci_pkg::ADR_EXT_RX, 8'h00, "rx_ext_divider");
    rd_reg(3'h7, 8'h00, "unmapped");
    wr_reg(sci_pkg::ADR_EXT_RX, 8'hFF);
    rd_reg(sci_pkg::ADR_EXT_RX, 8'hFF, "rx_ext_divider");
    wr_reg(sci_pkg::ADR_EXT_RX, 8'h00);
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h80);
    check("irq tx empty", 8'h01, {7'h00, irq});
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h00);
    check("irq masked", 8'h00, {7'h00, irq});
    rd_reg(sci_pkg::ADR_STATUS, 8'hC0, "status");
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h08);
    rd_reg(sci_pkg::ADR_CTRL_TWO, 8'h08, "control_two");
    wr_reg(sci_pkg::ADR_DATA, 8'hA5);
    sci_node_i.rx_byte(got, 16);
    check("tx byte", 8'hA5, got);
    // prescale 3, tx divide 2, rx divide 1
    wr_reg(sci_pkg::ADR_BAUD, 8'h48);
    rd_reg(sci_pkg::ADR_BAUD, 8'h48, "baud_select");
    wr_reg(sci_pkg::ADR_DATA, 8'h5A);
    sci_node_i.rx_byte(got, 96);
    check("tx byte slow", 8'h5A, got);
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h24);
    sci_node_i.send_byte(8'hC3, 48);
    repeat (20) @(posedge clk_sys);
    check("irq rx full", 8'h01, {7'h00, irq});
    // address wake: mute write refused while a word waits
    wr_reg(sci_pkg::ADR_CTRL_ONE, 8'h08);
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h26);
    rd_reg(sci_pkg::ADR_CTRL_TWO, 8'h24, "mute refused");
    wr_reg(sci_pkg::ADR_CTRL_ONE, 8'h00);
    rd_reg(sci_pkg::ADR_STATUS, 8'hE0, "status");
    rd_reg(sci_pkg::ADR_DATA, 8'hC3, "data_port");
    check("irq rx cleared", 8'h00, {7'h00, irq});
    // mute after a received byte; the idle line wakes it
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h26);
    repeat (600) @(posedge clk_sys);
    rd_reg(sci_pkg::ADR_CTRL_TWO, 8'h24, "mute woken");
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h09);
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h08);
    sci_node_i.rx_byte(got, 96);
    check("break word", 8'h00, got);
    wr_reg(sci_pkg::ADR_CTRL_TWO, 8'h48);
    check("irq tx done", 8'h01, {7'h00, irq});
    final_report();
  end
endmodule : sci_uart_tb_top
bind sci_uart sci_uart_assertions sci_uart_assertions_i (.CLK_SYS_I(CLK_SYS_I),
  .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .TXD_O(TXD_O), .RXD_I(RXD_I), .IRQ_O(IRQ_O));
